// *** hdl/socket_aux_map.svh ***
`ifndef SOCKET_AUX_MAP_SVH
`define SOCKET_AUX_MAP_SVH

// Timing
`define CLK_FREQ_HZ 25000000
`define LAMP_TIME_MS 64
`define LAMP_CYCLES ((`CLK_FREQ_HZ / 1000) * `LAMP_TIME_MS)
`define OSC_FREQ_HZ 16000
`define OSC_HALF_CYCLES (`CLK_FREQ_HZ / (2 * `OSC_FREQ_HZ))

// Field positions
`define SYSCTL_CLKEN_BIT 27
`define CARDCTL_CARD_SPEAKER_IN_EN_BIT 1
`define CARDCTL_PWM_ROUTE_BIT 2
`define PRESENT_ZV_SUPPORT_BIT 27
`define FORCE_ZV_SUPPORT_BIT 27
`define SOCKCTL_ZV_ENABLE_BIT 9
`define SOCKCTL_STD_MODEL_BIT 10
`define SOCKCTL_ZV_IN_USE_BIT 11

`endif

// *** hdl/socket_aux_pkg.sv ***
package socket_aux_pkg;
  typedef enum logic [1:0] {
    CARD_NONE,
    CARD_16BIT,
    CARD_CARDBUS
  } card_type_t;
  typedef enum logic {
    LAMP_OFF,
    LAMP_ON
  } lamp_state_t;
endpackage

// *** hdl/activity_lamp.sv ***
`timescale 1ns/10ps
`include "socket_aux_map.svh"
module activity_lamp #(
  parameter int unsigned LAMP_COUNT = `LAMP_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic activity,
  input wire logic forceOff,
  output logic lamp
);
  import socket_aux_pkg::*;

  lamp_state_t state;
  lamp_state_t next_state;
  logic [31:0] count;
  logic [31:0] next_count;

  // ----------------------------------------
  // Retriggerable interval
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_count = count;
    case (state)
      LAMP_OFF: begin
        if (activity && !forceOff) begin
          next_state = LAMP_ON;
          next_count = 32'h0000_0000;
        end
      end
      LAMP_ON: begin
        if (forceOff) begin
          next_state = LAMP_OFF; // RL19
        end else if (activity) begin
          next_count = 32'h0000_0000; // RL20
        end else if (count >= LAMP_COUNT - 1) begin
          next_state = LAMP_OFF; // RL15
        end else begin
          next_count = count + 32'h0000_0001; // RL23
        end
      end
      default: next_state = LAMP_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= LAMP_OFF;
      count <= 32'h0000_0000;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  assign lamp = (state == LAMP_ON); // RL15

  chk_lamp_force_off: assert property ( // RL19
    @(posedge clk) disable iff (!nrst) forceOff |=> !lamp)
    else $error("lamp on while forced off");
  chk_lamp_retrigger: assert property ( // RL20
    @(posedge clk) disable iff (!nrst)
    (activity && !forceOff) |=> lamp)
    else $error("lamp not lit after activity");
endmodule // activity_lamp

// *** hdl/socket_aux_signal_logic.sv ***
`timescale 1ns/10ps
`include "socket_aux_map.svh"
// Contract
// RL1 - Std flag zero: software uses legacy enable
// RL2 - Std flag one: software may use model
// RL3 - Supported and free: software sets enable
// RL4 - Supported but busy: software reports conflict
// RL5 - Unsupported: software reports, suggests other socket
// RL6 - Ring oscillator, off at reset, enable bit
// RL7 - Oscillator lets socket work without bus clock
// RL8 - Pullup for 16-bit, pulldown for CardBus
// RL9 - 16-bit I/O mode: battery pin is speaker
// RL10 - Speaker output is XOR of sockets
// RL11 - Speaker active only when enabled
// RL12 - Route bit sends PWM audio out
// RL13 - Both routing: socket 0 wins
// RL14 - Lamps per socket plus combined lamp
// RL15 - Lamp high 64 ms, else low
// RL16 - Activity only inserted, powered, out of reset
// RL17 - 16-bit activity: ready/irq low
// RL18 - CardBus activity: frame, irdy or request
// RL19 - Lamps forced off in suspend, clockrun, D1/D2
// RL20 - New activity restarts interval
// RL21 - In-use flag set when any enable
// RL22 - Force bit sets support, shown in present state
// RL23 - Interval counted from clock by parameter
// RL24 - No routing: PWM output low
module socket_aux_signal_logic #(
  parameter int unsigned LAMP_COUNT = `LAMP_CYCLES,
  parameter int unsigned OSC_HALF = `OSC_HALF_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic internal_clock_enable,
  input wire socket_aux_pkg::card_type_t cardType0,
  input wire socket_aux_pkg::card_type_t cardType1,
  input wire logic ioMode0,
  input wire logic ioMode1,
  input wire logic cardPowered0,
  input wire logic cardPowered1,
  input wire logic cardReset0,
  input wire logic cardReset1,
  input wire logic battery_detect_two0,
  input wire logic battery_detect_two1,
  input wire logic card_audio_in0,
  input wire logic card_audio_in1,
  input wire logic card_ready_irq0,
  input wire logic card_ready_irq1,
  input wire logic card_frame_n0,
  input wire logic card_frame_n1,
  input wire logic card_irdy_n0,
  input wire logic card_irdy_n1,
  input wire logic card_bus_request_n0,
  input wire logic card_bus_request_n1,
  input wire logic speaker_out_enable,
  input wire logic pwm_audio_route0,
  input wire logic pwm_audio_route1,
  input wire logic suspend,
  input wire logic clockStopPending,
  input wire logic lowPowerState,
  input wire logic force_zoom_support0,
  input wire logic force_zoom_support1,
  input wire logic zoom_socket_enable0,
  input wire logic zoom_socket_enable1,
  output logic ringClock,
  output logic statusPullUp0,
  output logic statusPullUp1,
  output logic statusPullDown0,
  output logic statusPullDown1,
  output logic speaker_out,
  output logic pwm_audio_out,
  output logic socket0_activity_lamp,
  output logic socket1_activity_lamp,
  output logic any_socket_activity_lamp,
  output logic zoom_platform_support0,
  output logic zoom_platform_support1,
  output logic zoom_in_use,
  output logic std_model_flag
);
  import socket_aux_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam int NS = 22;
  logic [NS-1:0] rawIn;
  logic [NS-1:0] syncA;
  logic [NS-1:0] syncB;
  logic [NS-1:0] next_syncA;
  logic [NS-1:0] next_syncB;

  assign rawIn = {card_ready_irq0, card_ready_irq1,
    card_frame_n0, card_frame_n1, card_irdy_n0, card_irdy_n1,
    card_bus_request_n0, card_bus_request_n1,
    battery_detect_two0, battery_detect_two1,
    card_audio_in0, card_audio_in1,
    cardPowered0, cardPowered1, cardReset0, cardReset1,
    suspend, clockStopPending, lowPowerState,
    ioMode0, ioMode1, internal_clock_enable};

  always_comb begin
    next_syncA = rawIn;
    next_syncB = syncA;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      syncA <= '0;
      syncB <= '0;
    end else begin
      syncA <= next_syncA;
      syncB <= next_syncB;
    end
  end

  logic rdy0, rdy1, frm0, frm1, ird0, ird1, req0, req1;
  logic bvd0, bvd1, aud0, aud1, pwr0, pwr1, rst0, rst1;
  logic susp, clkStop, lowPwr, io0, io1, oscEn;
  assign {rdy0, rdy1, frm0, frm1, ird0, ird1, req0, req1,
    bvd0, bvd1, aud0, aud1, pwr0, pwr1, rst0, rst1,
    susp, clkStop, lowPwr, io0, io1, oscEn} = syncB;

  // ----------------------------------------
  // Ring oscillator
  // ----------------------------------------
  logic [15:0] oscCount;
  logic [15:0] next_oscCount;
  logic next_ringClock;

  always_comb begin
    next_oscCount = 16'h0000;
    next_ringClock = 1'b0; // RL6
    if (oscEn) begin
      next_ringClock = ringClock;
      next_oscCount = oscCount + 16'h0001;
      if (oscCount >= 16'(OSC_HALF - 1)) begin
        next_oscCount = 16'h0000;
        next_ringClock = !ringClock; // RL7
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      oscCount <= 16'h0000;
      ringClock <= 1'b0;
    end else begin
      oscCount <= next_oscCount;
      ringClock <= next_ringClock;
    end
  end

  // ----------------------------------------
  // Status-change pin pulls and audio
  // ----------------------------------------
  function automatic logic cardAudio(input card_type_t t,
      input logic io, input logic bvd, input logic aud);
    cardAudio = (t == CARD_16BIT) ? (io & bvd) : // RL9
      ((t == CARD_CARDBUS) ? aud : 1'b0);
  endfunction

  logic next_speaker;
  logic next_pwm;

  always_comb begin
    next_speaker = 1'b0;
    if (speaker_out_enable) begin // RL11
      next_speaker = cardAudio(cardType0, io0, bvd0, aud0) ^
        cardAudio(cardType1, io1, bvd1, aud1); // RL10
    end
    next_pwm = 1'b0; // RL24
    if (pwm_audio_route0 && cardType0 == CARD_CARDBUS) begin
      next_pwm = aud0; // RL13
    end else if (pwm_audio_route1 && cardType1 == CARD_CARDBUS) begin
      next_pwm = aud1; // RL12
    end
  end

  logic next_pu0, next_pu1, next_pd0, next_pd1;
  always_comb begin
    next_pu0 = (cardType0 == CARD_16BIT); // RL8
    next_pu1 = (cardType1 == CARD_16BIT); // RL8
    next_pd0 = (cardType0 == CARD_CARDBUS); // RL8
    next_pd1 = (cardType1 == CARD_CARDBUS); // RL8
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      speaker_out <= 1'b0;
      pwm_audio_out <= 1'b0;
      statusPullUp0 <= 1'b0;
      statusPullUp1 <= 1'b0;
      statusPullDown0 <= 1'b0;
      statusPullDown1 <= 1'b0;
    end else begin
      speaker_out <= next_speaker;
      pwm_audio_out <= next_pwm;
      statusPullUp0 <= next_pu0;
      statusPullUp1 <= next_pu1;
      statusPullDown0 <= next_pd0;
      statusPullDown1 <= next_pd1;
    end
  end

  // ----------------------------------------
  // Zoomed-video flags
  // ----------------------------------------
  logic next_sup0, next_sup1, next_inUse;
  always_comb begin
    next_sup0 = zoom_platform_support0 | force_zoom_support0; // RL22
    next_sup1 = zoom_platform_support1 | force_zoom_support1; // RL22
    next_inUse = zoom_socket_enable0 | zoom_socket_enable1; // RL21
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      zoom_platform_support0 <= 1'b0;
      zoom_platform_support1 <= 1'b0;
      zoom_in_use <= 1'b0;
    end else begin
      zoom_platform_support0 <= next_sup0;
      zoom_platform_support1 <= next_sup1;
      zoom_in_use <= next_inUse;
    end
  end

  assign std_model_flag = 1'b1; // RL2

  // ----------------------------------------
  // Activity lamps
  // ----------------------------------------
  function automatic logic sockActive(input card_type_t t,
      input logic pwr, input logic rst, input logic rdy,
      input logic frm, input logic ird, input logic req);
    logic hit;
    hit = (t == CARD_16BIT) ? !rdy : // RL17
      ((t == CARD_CARDBUS) ? (!frm | !ird | !req) : 1'b0); // RL18
    sockActive = hit & pwr & !rst; // RL16
  endfunction

  logic act0, act1, lampOff;
  assign act0 = sockActive(cardType0, pwr0, rst0, rdy0, frm0, ird0, req0);
  assign act1 = sockActive(cardType1, pwr1, rst1, rdy1, frm1, ird1, req1);
  assign lampOff = susp | clkStop | lowPwr; // RL19

  activity_lamp #(.LAMP_COUNT(LAMP_COUNT)) lamp0 (
    .clk(clk), .nrst(nrst), .activity(act0), .forceOff(lampOff),
    .lamp(socket0_activity_lamp)); // RL14
  activity_lamp #(.LAMP_COUNT(LAMP_COUNT)) lamp1 (
    .clk(clk), .nrst(nrst), .activity(act1), .forceOff(lampOff),
    .lamp(socket1_activity_lamp)); // RL14
  activity_lamp #(.LAMP_COUNT(LAMP_COUNT)) lampAny (
    .clk(clk), .nrst(nrst), .activity(act0 | act1),
    .forceOff(lampOff), .lamp(any_socket_activity_lamp)); // RL14

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_speaker_gate: assert property ( // RL11
    @(posedge clk) disable iff (!nrst)
    !speaker_out_enable |=> !speaker_out)
    else $error("speaker active while disabled");
  chk_pwm_idle_low: assert property ( // RL24
    @(posedge clk) disable iff (!nrst)
    (!pwm_audio_route0 && !pwm_audio_route1) |=> !pwm_audio_out)
    else $error("pwm output not low");
  chk_pwm_priority: assert property ( // RL13
    @(posedge clk) disable iff (!nrst)
    (pwm_audio_route0 && cardType0 == CARD_CARDBUS)
    |=> pwm_audio_out == $past(aud0))
    else $error("pwm not from socket 0");
  chk_osc_disabled: assert property ( // RL6
    @(posedge clk) disable iff (!nrst) !oscEn |=> !ringClock)
    else $error("oscillator running while disabled");
  chk_pull_type: assert property ( // RL8
    @(posedge clk) disable iff (!nrst)
    (cardType0 == CARD_CARDBUS) |=> statusPullDown0 && !statusPullUp0)
    else $error("wrong pull on status pin");
  chk_inuse_flag: assert property ( // RL21
    @(posedge clk) disable iff (!nrst)
    zoom_socket_enable1 |=> zoom_in_use)
    else $error("in-use flag not set");
  chk_lamp_gated: assert property ( // RL16
    @(posedge clk) disable iff (!nrst)
    (!pwr0 && !socket0_activity_lamp) |=> !socket0_activity_lamp)
    else $error("lamp lit for unpowered socket");
  chk_any_lamp: assert property ( // RL14
    @(posedge clk) disable iff (!nrst)
    socket0_activity_lamp |-> any_socket_activity_lamp)
    else $error("combined lamp missing");
  chk_lamp1_gated: assert property ( // RL16
    @(posedge clk) disable iff (!nrst)
    (!pwr1 && !socket1_activity_lamp) |=> !socket1_activity_lamp)
    else $error("lamp lit for unpowered socket 1");
  chk_inuse_sock0: assert property ( // RL21
    @(posedge clk) disable iff (!nrst)
    zoom_socket_enable0 |=> zoom_in_use)
    else $error("in-use flag not set for socket 0");
  chk_pwm_route1: assert property ( // RL12
    @(posedge clk) disable iff (!nrst)
    (pwm_audio_route1 && !pwm_audio_route0 && cardType1 == CARD_CARDBUS)
    |=> pwm_audio_out == $past(aud1))
    else $error("pwm not from socket 1");
  cov_zoom_use: cover property (@(posedge clk) zoom_in_use);
  cov_lamp_on: cover property (@(posedge clk) socket0_activity_lamp);
  cov_pwm_both: cover property (@(posedge clk)
    pwm_audio_route0 && pwm_audio_route1);
  cov_speaker: cover property (@(posedge clk) speaker_out);
endmodule // socket_aux_signal_logic

// *** tb/card_socket_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// Card side of one socket, lines pulled up
// ----------------------------------------
module card_socket_model (
  input wire logic clk,
  output logic readyIrq,
  output logic frameN,
  output logic irdyN,
  output logic reqN
);
  initial begin
    {readyIrq, frameN, irdyN, reqN} = 4'hf;
  end
  // One low cycle: 0 ready/irq, 1 frame, 2 irdy, 3 request
  task automatic strobe(input int kind);
    @(posedge clk);
    #1;
    case (kind)
      0: readyIrq = 1'h0;
      1: frameN = 1'h0;
      2: irdyN = 1'h0;
      default: reqN = 1'h0;
    endcase
    @(posedge clk);
    #1;
    {readyIrq, frameN, irdyN, reqN} = 4'hf;
  endtask
endmodule // card_socket_model

// *** tb/tb.sv ***
`timescale 1ns/10ps
module tb;
  import socket_aux_pkg::*;
  localparam int unsigned LC = 20;
  logic clk = 1'h0, nrst = 1'h0, internal_clock_enable = 1'h0;
  card_type_t cardType0 = CARD_NONE, cardType1 = CARD_NONE;
  logic ioMode0 = 1'h0, ioMode1 = 1'h0, cardPowered0 = 1'h0;
  logic cardPowered1 = 1'h0, cardReset0 = 1'h0, cardReset1 = 1'h0;
  logic battery_detect_two0 = 1'h0, battery_detect_two1 = 1'h0;
  logic card_audio_in0 = 1'h0, card_audio_in1 = 1'h0;
  logic speaker_out_enable = 1'h0, suspend = 1'h0;
  logic pwm_audio_route0 = 1'h0, pwm_audio_route1 = 1'h0;
  logic clockStopPending = 1'h0, lowPowerState = 1'h0;
  logic force_zoom_support0 = 1'h0, force_zoom_support1 = 1'h0;
  logic zoom_socket_enable0 = 1'h0, zoom_socket_enable1 = 1'h0;
  logic card_ready_irq0, card_frame_n0, card_irdy_n0, card_bus_request_n0;
  logic card_ready_irq1, card_frame_n1, card_irdy_n1, card_bus_request_n1;
  logic ringClock, statusPullUp0, statusPullUp1, statusPullDown0;
  logic statusPullDown1, speaker_out, pwm_audio_out, zoom_in_use;
  logic socket0_activity_lamp, socket1_activity_lamp;
  logic any_socket_activity_lamp, std_model_flag, prev;
  logic zoom_platform_support0, zoom_platform_support1;
  int errors = 0, samples_checked = 0, n;
  always #20 clk = ~clk;
  card_socket_model sock0 (.clk, .readyIrq(card_ready_irq0),
    .frameN(card_frame_n0), .irdyN(card_irdy_n0),
    .reqN(card_bus_request_n0));
  card_socket_model sock1 (.clk, .readyIrq(card_ready_irq1),
    .frameN(card_frame_n1), .irdyN(card_irdy_n1),
    .reqN(card_bus_request_n1));
  socket_aux_signal_logic #(.LAMP_COUNT(LC), .OSC_HALF(4))
    socket_aux_signal_logic_i (.clk, .nrst, .internal_clock_enable,
    .cardType0, .cardType1, .ioMode0, .ioMode1, .cardPowered0,
    .cardPowered1, .cardReset0, .cardReset1, .battery_detect_two0,
    .battery_detect_two1, .card_audio_in0, .card_audio_in1,
    .card_ready_irq0, .card_ready_irq1, .card_frame_n0, .card_frame_n1,
    .card_irdy_n0, .card_irdy_n1, .card_bus_request_n0,
    .card_bus_request_n1, .speaker_out_enable, .pwm_audio_route0,
    .pwm_audio_route1, .suspend, .clockStopPending, .lowPowerState,
    .force_zoom_support0, .force_zoom_support1, .zoom_socket_enable0,
    .zoom_socket_enable1, .ringClock, .statusPullUp0, .statusPullUp1,
    .statusPullDown0, .statusPullDown1, .speaker_out, .pwm_audio_out,
    .socket0_activity_lamp, .socket1_activity_lamp,
    .any_socket_activity_lamp, .zoom_platform_support0,
    .zoom_platform_support1, .zoom_in_use, .std_model_flag);
  // ----------
  // Bench tasks
  // ----------
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wait_off(input int s, output int cnt);
    cnt = 0;
    while ((s ? socket1_activity_lamp : socket0_activity_lamp) !== 1'h0)
      begin
      step(1);
      cnt++;
      if (cnt > 200) begin
        errors++;
        finish_test;
      end
    end
  endtask
  // Host zoom procedure for one socket
  task automatic sw_zoom(input int s);
    logic sup;
    logic oth;
    sup = s ? zoom_platform_support1 : zoom_platform_support0;
    oth = s ? zoom_platform_support0 : zoom_platform_support1;
    if (std_model_flag !== 1'h1) $display("zoom: legacy path");
    else if (sup === 1'h1 && zoom_in_use === 1'h0) begin
      if (s == 1) zoom_socket_enable1 = 1'h1;
      else zoom_socket_enable0 = 1'h1;
    end else if (sup === 1'h1) $display("zoom: held by other card");
    else if (oth === 1'h1) $display("zoom: use other socket");
    else $display("zoom: unsupported");
    step(3);
  endtask
  // ----------
  // Main sequence
  // ----------
  initial begin
    step(4);
    nrst = 1'h1;
    step(1);
    check(std_model_flag, 1'h1);
    check(ringClock, 1'h0);
    internal_clock_enable = 1'h1;
    step(6);
    n = 0;
    repeat (32) begin
      prev = ringClock;
      step(1);
      if (ringClock !== prev) n++;
    end
    check(n >= 6 && n <= 8, 1'h1);
    internal_clock_enable = 1'h0;
    step(12);
    check(ringClock, 1'h0);
    cardType0 = CARD_16BIT;
    cardType1 = CARD_CARDBUS;
    step(2);
    check({statusPullUp0, statusPullDown0, statusPullUp1, statusPullDown1},
      4'h9);
    {cardPowered0, cardPowered1, ioMode0, speaker_out_enable} = 4'hf;
    for (int i = 0; i < 4; i++) begin
      battery_detect_two0 = i[0];
      card_audio_in1 = i[1];
      step(5);
      check(speaker_out, i[0] ^ i[1]);
    end
    battery_detect_two0 = 1'h1;
    card_audio_in1 = 1'h0;
    speaker_out_enable = 1'h0;
    step(5);
    check(speaker_out, 1'h0);
    speaker_out_enable = 1'h1;
    ioMode0 = 1'h0;
    step(5);
    check(speaker_out, 1'h0);
    cardType1 = CARD_16BIT;
    {ioMode1, battery_detect_two1} = 2'h3;
    step(5);
    check(speaker_out, 1'h1);
    sock1.strobe(0);
    step(3);
    check({socket0_activity_lamp, socket1_activity_lamp,
      any_socket_activity_lamp}, 3'h3);
    wait_off(1, n);
    cardType1 = CARD_CARDBUS;
    cardType0 = CARD_CARDBUS;
    for (int i = 0; i < 4; i++) begin
      {pwm_audio_route1, pwm_audio_route0} = i[1:0];
      card_audio_in0 = (i != 2);
      card_audio_in1 = (i == 2) || (i == 0);
      step(5);
      check(pwm_audio_out, i != 0);
    end
    {card_audio_in0, card_audio_in1} = 2'h0;
    cardType0 = CARD_16BIT;
    sock0.strobe(0);
    step(3);
    check({socket0_activity_lamp, socket1_activity_lamp,
      any_socket_activity_lamp}, 3'h5);
    wait_off(0, n);
    check(n >= LC - 4 && n <= LC + 1, 1'h1);
    check(any_socket_activity_lamp, 1'h0);
    sock0.strobe(0);
    repeat (4) begin
      step(LC - 5);
      check(socket0_activity_lamp, 1'h1);
      sock0.strobe(0);
    end
    wait_off(0, n);
    check(n >= LC - 4, 1'h1);
    cardReset0 = 1'h1;
    step(3);
    sock0.strobe(0);
    step(4);
    check(socket0_activity_lamp, 1'h0);
    cardReset0 = 1'h0;
    step(3);
    for (int k = 1; k < 4; k++) begin
      sock1.strobe(k);
      step(3);
      check({socket0_activity_lamp, socket1_activity_lamp,
        any_socket_activity_lamp}, 3'h3);
      wait_off(1, n);
    end
    for (int q = 0; q < 3; q++) begin
      if (q == 0) cardPowered1 = 1'h0;
      else if (q == 1) cardReset1 = 1'h1;
      else cardType1 = CARD_NONE;
      step(3);
      sock1.strobe(1);
      step(4);
      check(any_socket_activity_lamp, 1'h0);
      {cardPowered1, cardReset1} = 2'h2;
      cardType1 = CARD_CARDBUS;
      step(3);
    end
    for (int f = 0; f < 3; f++) begin
      sock1.strobe(1);
      step(3);
      check(socket1_activity_lamp, 1'h1);
      {suspend, clockStopPending, lowPowerState} = 3'h1 << f;
      step(4);
      check(socket1_activity_lamp, 1'h0);
      sock1.strobe(2);
      step(4);
      check(any_socket_activity_lamp, 1'h0);
      {suspend, clockStopPending, lowPowerState} = 3'h0;
      step(3);
    end
    wait_off(1, n);
    force_zoom_support0 = 1'h1;
    step(1);
    force_zoom_support0 = 1'h0;
    step(2);
    check({zoom_platform_support0, zoom_platform_support1}, 2'h2);
    sw_zoom(0);
    check(zoom_in_use, 1'h1);
    sw_zoom(1);
    force_zoom_support1 = 1'h1;
    step(1);
    force_zoom_support1 = 1'h0;
    step(2);
    sw_zoom(1);
    check(zoom_socket_enable1, 1'h0);
    zoom_socket_enable0 = 1'h0;
    step(3);
    check(zoom_in_use, 1'h0);
    sw_zoom(1);
    check({zoom_in_use, zoom_platform_support1}, 2'h3);
    finish_test;
  end
endmodule // tb
